// ---- rtl/pcsa_defs.svh ----
/*
  constants for the program counter, return stack and indirect addressing block.
  assumes it is included by bare name from rtl/ and test/ files.
*/
`ifndef PCSA_DEFS_SVH
`define PCSA_DEFS_SVH

`define PCSA_PC_W 13
`define PCSA_HI_W 5
`define PCSA_TGT_W 11
`define PCSA_STK_DEPTH 8
`define PCSA_PTR_W 3
`define PCSA_DADDR_W 9

`define PCSA_ADDR_WINDOW 8'h00
`define PCSA_ADDR_PCLOW 8'h01
`define PCSA_ADDR_STATUS 8'h02
`define PCSA_ADDR_FPTR 8'h03
`define PCSA_ADDR_LATCH 8'h04

`define PCSA_BANK_BIT 7
`define PCSA_JMP_HI_MSB 4
`define PCSA_JMP_HI_LSB 3

`define PCSA_RST_PC 13'h0000
`define PCSA_RST_BYTE 8'h00
`define PCSA_IRQ_VECTOR 13'h0004

`endif

// ---- rtl/pcsa_pkg.sv ----
/*
  types shared by the program counter block and its return stack.
  assumes pcsa_defs.svh sits beside it.
*/
`include "pcsa_defs.svh"

package pcsa_pkg;

  typedef enum logic [2:0] {
    PCSA_OP_NONE,
    PCSA_OP_NEXT,
    PCSA_OP_JUMP,
    PCSA_OP_CALL,
    PCSA_OP_IRQ,
    PCSA_OP_RET,
    PCSA_OP_RETURN_WITH_LITERAL,
    PCSA_OP_INTERRUPT_EXIT
  } pcsa_op_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pcsa_bus_t;

  typedef struct packed {
    pcsa_op_t op;
    logic [`PCSA_TGT_W-1:0] target;
  } pcsa_ctl_t;

endpackage : pcsa_pkg

// ---- rtl/pcsa_stack.sv ----
/*
  eight-entry circular return stack of program counter values.
  assumes push and pop are never high together; the caller orders them.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcsa_defs.svh"

module pcsa_stack
  import pcsa_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [`PCSA_PC_W-1:0] push_data,
  output logic [`PCSA_PC_W-1:0] top
);

  logic [`PCSA_PTR_W-1:0] ptr_q;
  logic [`PCSA_PTR_W-1:0] ptr_d;
  logic [`PCSA_PTR_W-1:0] top_idx;
  logic [`PCSA_PC_W-1:0] entry_q [`PCSA_STK_DEPTH];

  // pointer wraps modulo eight both ways, no overflow or underflow flag
  assign ptr_d = push ? ptr_q + 3'h1 : (pop ? ptr_q - 3'h1 : ptr_q);
  assign top_idx = ptr_q - 3'h1;
  assign top = entry_q[top_idx];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ptr_q <= '0;
    else
      ptr_q <= ptr_d;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PCSA_STK_DEPTH; gi++)
    begin : g_entry
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          entry_q[gi] <= `PCSA_RST_PC;
        else if (push && ptr_q == 3'(gi))
          entry_q[gi] <= push_data;
      end
    end
  endgenerate

endmodule : pcsa_stack

`default_nettype wire

// ---- rtl/pcsa_core.sv ----
/*
  program counter, return stack control and indirect data addressing.
  assumes the instruction decoder drives ctl and the register port, one strobe a cycle,
  and that data memory answers mem_rdata combinationally to mem_addr.
*/
// Function
// - program counter is 13 bits; low byte readable, upper five only via latch
// - any reset clears the whole program counter
// - writing the low byte also loads upper bits from latch bits 4:0
// - jumps and calls take the top two counter bits from latch bits 4:3
// - eight return entries of 13 bits, pointer hidden from software
// - calls push the program counter plus one; interrupt vectoring pushes the program counter
// - the three return kinds pop the stack into the program counter
// - pushes and pops leave the latch unchanged
// - stack is circular; the ninth push overwrites the first entry
// - no overflow or underflow status; only calls, returns, vectoring move stack
// - indirect window has no storage; it reaches the pointer's target
// - reading the window through a pointer at itself gives 00h
// - writing the window through a pointer at itself stores nothing
// - indirect address is bank bit joined with the 8-bit pointer
`timescale 1ns/1ps
`default_nettype none
`include "pcsa_defs.svh"

module pcsa_core
  import pcsa_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire pcsa_bus_t bus,
  input wire pcsa_ctl_t ctl,
  input wire logic [7:0] mem_rdata,
  output logic [7:0] rd_data,
  output logic [`PCSA_PC_W-1:0] pc,
  output logic [`PCSA_DADDR_W-1:0] mem_addr,
  output logic mem_we,
  output logic [7:0] mem_wdata
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  logic [`PCSA_PC_W-1:0] pc_q;
  logic [`PCSA_PC_W-1:0] pc_d;
  logic [7:0] latch_q;
  logic [7:0] fptr_q;
  logic bank_q;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic mem_we_q;
  logic [7:0] mem_wdata_q;
  logic [`PCSA_DADDR_W-1:0] mem_addr_q;
  logic [`PCSA_PC_W-1:0] stk_top;
  logic [`PCSA_PC_W-1:0] push_val;

  // register port decode
  wire wr_pcl = bus.wr && hit(bus.addr, `PCSA_ADDR_PCLOW);
  wire wr_latch = bus.wr && hit(bus.addr, `PCSA_ADDR_LATCH);
  wire wr_fptr = bus.wr && hit(bus.addr, `PCSA_ADDR_FPTR);
  wire wr_status = bus.wr && hit(bus.addr, `PCSA_ADDR_STATUS);
  wire wr_window = bus.wr && hit(bus.addr, `PCSA_ADDR_WINDOW);
  wire self_ptr = hit(fptr_q, `PCSA_ADDR_WINDOW);

  // stack control
  wire do_push = !wr_pcl && (ctl.op == PCSA_OP_CALL || ctl.op == PCSA_OP_IRQ);
  wire do_pop = !wr_pcl && (ctl.op == PCSA_OP_RET || ctl.op == PCSA_OP_RETURN_WITH_LITERAL
                            || ctl.op == PCSA_OP_INTERRUPT_EXIT);
  wire [`PCSA_PC_W-1:0] pc_inc = pc_q + 13'h0001;
  wire [`PCSA_PC_W-1:0] pc_pcl = {latch_q[`PCSA_HI_W-1:0], bus.wdata};
  wire [`PCSA_PC_W-1:0] pc_jmp = {latch_q[`PCSA_JMP_HI_MSB:`PCSA_JMP_HI_LSB], ctl.target};

  assign push_val = (ctl.op == PCSA_OP_IRQ) ? pc_q : pc_inc;

  // next program counter, low byte write has priority
  always_comb
  begin
    pc_d = pc_q;
    if (wr_pcl)
      pc_d = pc_pcl;
    else
    begin
      case (ctl.op)
        PCSA_OP_NEXT: pc_d = pc_inc;
        PCSA_OP_JUMP: pc_d = pc_jmp;
        PCSA_OP_CALL: pc_d = pc_jmp;
        PCSA_OP_IRQ: pc_d = `PCSA_IRQ_VECTOR;
        PCSA_OP_RET: pc_d = stk_top;
        PCSA_OP_RETURN_WITH_LITERAL: pc_d = stk_top;
        PCSA_OP_INTERRUPT_EXIT: pc_d = stk_top;
        default: pc_d = pc_q;
      endcase
    end
  end

  // read data, window reads go to memory through the pointer, 00h when it points at the window
  always_comb
  begin
    rd_data_d = `PCSA_RST_BYTE;
    case (bus.addr)
      `PCSA_ADDR_WINDOW: rd_data_d = self_ptr ? 8'h00 : mem_rdata;
      `PCSA_ADDR_PCLOW: rd_data_d = pc_q[7:0];
      `PCSA_ADDR_STATUS: rd_data_d = {bank_q, 7'h00};
      `PCSA_ADDR_FPTR: rd_data_d = fptr_q;
      `PCSA_ADDR_LATCH: rd_data_d = latch_q;
      default: rd_data_d = `PCSA_RST_BYTE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pc_q <= `PCSA_RST_PC;
    else
      pc_q <= pc_d;
  end

  // latch only moves on its own write, never on stack or counter events
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      latch_q <= `PCSA_RST_BYTE;
    else if (wr_latch)
      latch_q <= bus.wdata;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      fptr_q <= `PCSA_RST_BYTE;
    else if (wr_fptr)
      fptr_q <= bus.wdata;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      bank_q <= 1'b0;
    else if (wr_status)
      bank_q <= bus.wdata[`PCSA_BANK_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mem_addr_q <= '0;
    else
      mem_addr_q <= {wr_status ? bus.wdata[`PCSA_BANK_BIT] : bank_q,
                     wr_fptr ? bus.wdata : fptr_q};
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mem_we_q <= 1'b0;
    else
      mem_we_q <= wr_window && !self_ptr;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mem_wdata_q <= `PCSA_RST_BYTE;
    else if (wr_window)
      mem_wdata_q <= bus.wdata;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rd_data_q <= `PCSA_RST_BYTE;
    else if (bus.rd)
      rd_data_q <= rd_data_d;
    else
      rd_data_q <= `PCSA_RST_BYTE;
  end

  pcsa_stack u_stack (
    .clk(clk),
    .sys_rst(sys_rst),
    .push(do_push),
    .pop(do_pop),
    .push_data(push_val),
    .top(stk_top)
  );

  assign pc = pc_q;
  assign rd_data = rd_data_q;
  assign mem_addr = mem_addr_q;
  assign mem_we = mem_we_q;
  assign mem_wdata = mem_wdata_q;

  // helper: shadow depth for stack checks
  logic [3:0] depth_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      depth_q <= 4'h0;
    else if (do_push && depth_q != 4'h8)
      depth_q <= depth_q + 4'h1;
    else if (do_pop && depth_q != 4'h0)
      depth_q <= depth_q - 4'h1;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_pc_reset_clear: assert property (
    $past(sys_rst) |-> pc == 13'h0000)
    else $error("program counter not cleared by reset");

  a_pcl_write_load: assert property (
    wr_pcl |=> pc == {$past(latch_q[4:0]), $past(bus.wdata)})
    else $error("low byte write did not load all thirteen bits");

  a_jump_high_bits: assert property (
    (!wr_pcl && (ctl.op == PCSA_OP_JUMP || ctl.op == PCSA_OP_CALL))
    |=> pc[12:11] == $past(latch_q[4:3]) && pc[10:0] == $past(ctl.target))
    else $error("jump upper bits not from latch 4:3");

  a_call_return_pair: assert property (
    (!wr_pcl && ctl.op == PCSA_OP_CALL) ##1 (!wr_pcl && ctl.op == PCSA_OP_RET)
    |=> pc == $past(pc, 2) + 13'h0001)
    else $error("return did not restore address after call");

  a_irq_push_pop: assert property (
    (!wr_pcl && ctl.op == PCSA_OP_IRQ) ##1 (!wr_pcl && ctl.op == PCSA_OP_INTERRUPT_EXIT)
    |=> pc == $past(pc, 2))
    else $error("interrupt exit did not restore interrupted address");

  a_latch_stack_stable: assert property (
    (do_push || do_pop) && !wr_latch |=> $stable(latch_q))
    else $error("latch moved on stack action");

  a_step_wrap: assert property (
    (!wr_pcl && ctl.op == PCSA_OP_NEXT && pc == 13'h1fff) |=> pc == 13'h0000)
    else $error("counter did not wrap in thirteen bits");

  a_window_self_read: assert property (
    (bus.rd && bus.addr == `PCSA_ADDR_WINDOW && self_ptr) |=> rd_data == 8'h00)
    else $error("self indirect read not zero");

  a_window_self_write: assert property (
    (wr_window && self_ptr) |=> !mem_we)
    else $error("self indirect write reached memory");

  a_window_write_path: assert property (
    (wr_window && !self_ptr) |=> mem_we && mem_wdata == $past(bus.wdata))
    else $error("indirect write not forwarded");

  a_addr_form: assert property (
    wr_fptr && !wr_status |=> mem_addr == {bank_q, $past(bus.wdata)})
    else $error("indirect address not bank joined with pointer");

  a_stack_push_top: assert property (
    do_push |=> stk_top == $past(push_val))
    else $error("pushed value not on top of stack");

  a_call_push_next: assert property (
    (!wr_pcl && ctl.op == PCSA_OP_CALL) |=> stk_top == $past(pc) + 13'h0001)
    else $error("call did not push return address");

  a_irq_push_pc: assert property (
    (!wr_pcl && ctl.op == PCSA_OP_IRQ) |=> stk_top == $past(pc))
    else $error("vectoring did not push program counter");

  a_irq_vector_load: assert property (
    (!wr_pcl && ctl.op == PCSA_OP_IRQ) |=> pc == `PCSA_IRQ_VECTOR)
    else $error("vectoring did not load vector address");

  a_pop_loads_top: assert property (
    do_pop |=> pc == $past(stk_top))
    else $error("return did not load stack top");

  a_step_plus_one: assert property (
    (!wr_pcl && ctl.op == PCSA_OP_NEXT) |=> pc == $past(pc) + 13'h0001)
    else $error("counter did not step by one");

  a_idle_pc_hold: assert property (
    (!wr_pcl && ctl.op == PCSA_OP_NONE) |=> pc == $past(pc))
    else $error("counter moved without a command");

  a_pcl_read_back: assert property (
    (bus.rd && bus.addr == `PCSA_ADDR_PCLOW) |=> rd_data == $past(pc[7:0]))
    else $error("low byte read wrong");

  a_read_idle_zero: assert property (
    !bus.rd |=> rd_data == 8'h00)
    else $error("read data not zero outside a read");

  a_latch_read_back: assert property (
    (bus.rd && bus.addr == `PCSA_ADDR_LATCH) |=> rd_data == $past(latch_q))
    else $error("latch read wrong");

  a_status_bank_read: assert property (
    (bus.rd && bus.addr == `PCSA_ADDR_STATUS) |=> rd_data == {$past(bank_q), 7'h00})
    else $error("status read wrong");

  a_window_read_path: assert property (
    (bus.rd && bus.addr == `PCSA_ADDR_WINDOW && !self_ptr) |=> rd_data == $past(mem_rdata))
    else $error("indirect read not forwarded");

  a_no_window_write: assert property (
    !wr_window |=> !mem_we)
    else $error("memory write without window write");

  a_wdata_hold: assert property (
    !wr_window |=> $stable(mem_wdata))
    else $error("memory write data moved without window write");

  a_bank_top_bit: assert property (
    (wr_status && !wr_fptr)
    |=> mem_addr[`PCSA_DADDR_W-1] == $past(bus.wdata[`PCSA_BANK_BIT]))
    else $error("bank bit not top of address");

  a_addr_hold: assert property (
    (!wr_fptr && !wr_status) |=> $stable(mem_addr))
    else $error("indirect address moved without write");

  c_call_return: cover property (
    (ctl.op == PCSA_OP_CALL) ##[1:20] (ctl.op == PCSA_OP_RET));

  c_ninth_push: cover property (
    depth_q == 4'h8 && do_push);

  c_self_read: cover property (
    bus.rd && bus.addr == `PCSA_ADDR_WINDOW && self_ptr);

  c_pcl_write: cover property (
    wr_pcl && latch_q[4:0] != 5'h00);

  c_irq_return: cover property (
    (ctl.op == PCSA_OP_IRQ) ##1 (ctl.op == PCSA_OP_INTERRUPT_EXIT));

endmodule : pcsa_core

`default_nettype wire

// ---- test/pcsa_dmem.sv ----
/*
  data memory model at the far side of the indirect path of pcsa_core.
  assumes one clock; reads answer mem_addr at once, writes land on mem_we.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcsa_defs.svh"

module pcsa_dmem (
  input wire logic clk,
  input wire logic [`PCSA_DADDR_W-1:0] mem_addr,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:511];

  // every location but 0FFh and 1FFh starts nonzero so a forced 00h read stands out
  initial
  begin
    for (int i = 0; i < 512; i++)
      mem[i] = ~i[7:0];
  end

  always @(posedge clk)
  begin
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
  end

  assign mem_rdata = mem[mem_addr];
endmodule : pcsa_dmem
`default_nettype wire

// ---- test/testbench.sv ----
/*
  self-checking bench for pcsa_core: register port, control port and indirect path.
  assumes rtl/ on the include path and pcsa_dmem as the data memory.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcsa_defs.svh"

module testbench
  import pcsa_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  pcsa_bus_t bus = '0;
  pcsa_ctl_t ctl = '0;
  logic [7:0] mem_rdata, rd_data, mem_wdata;
  logic [`PCSA_PC_W-1:0] pc, saved;
  logic [`PCSA_DADDR_W-1:0] mem_addr;
  logic mem_we;
  logic [`PCSA_PC_W-1:0] exp_q[$];
  pcsa_op_t pops[3] = '{PCSA_OP_RET, PCSA_OP_RETURN_WITH_LITERAL, PCSA_OP_INTERRUPT_EXIT};
  int failures = 0;
  int total_checks = 0;

  always #12.5 clk = ~clk;

  pcsa_core i_pcsa_core (.clk(clk), .sys_rst(sys_rst), .bus(bus), .ctl(ctl),
    .mem_rdata(mem_rdata), .rd_data(rd_data), .pc(pc), .mem_addr(mem_addr),
    .mem_we(mem_we), .mem_wdata(mem_wdata));
  pcsa_dmem i_pcsa_dmem (.clk(clk), .mem_addr(mem_addr), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  task automatic finish_test;
    $display("checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk_pc(input logic [`PCSA_PC_W-1:0] exp);
    total_checks++;
    if (pc !== exp)
    begin
      failures++;
      $display("wrong value at %0t: pc %h expected %h", $time, pc, exp);
    end
  endtask : chk_pc

  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: data %h expected %h", $time, got, exp);
    end
  endtask : chk_data

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk_data({8'h00, rd_data}, {8'h00, exp});
  endtask : rd_chk

  task automatic op(input pcsa_op_t o, input logic [10:0] t);
    @(posedge clk);
    ctl <= '{op: o, target: t};
    @(posedge clk);
    ctl.op <= PCSA_OP_NONE;
    #1;
  endtask : op

  task automatic op2(input pcsa_op_t o1, input pcsa_op_t o2);
    @(posedge clk);
    ctl <= '{op: o1, target: 11'h200};
    @(posedge clk);
    ctl <= '{op: o2, target: 11'h000};
    @(posedge clk);
    ctl.op <= PCSA_OP_NONE;
    #1;
  endtask : op2

  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    finish_test;
  end

  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk_pc(13'h0000);
    op(PCSA_OP_NEXT, 11'h000);
    op(PCSA_OP_NEXT, 11'h000);
    chk_pc(13'h0002);
    wr(8'h04, 8'h1F);
    wr(8'h01, 8'hFF);
    chk_pc(13'h1FFF);
    rd_chk(8'h01, 8'hFF);
    op(PCSA_OP_NEXT, 11'h000);
    chk_pc(13'h0000);
    // table walk across a low byte rollover
    wr(8'h04, 8'h02);
    wr(8'h01, 8'hFF);
    op(PCSA_OP_NEXT, 11'h000);
    chk_pc(13'h0300);
    rd_chk(8'h04, 8'h02);
    wr(8'h04, 8'h03);
    wr(8'h01, 8'h05);
    chk_pc(13'h0305);
    wr(8'h04, 8'h18);
    op(PCSA_OP_JUMP, 11'h123);
    chk_pc(13'h1923);
    wr(8'h04, 8'h0F);
    op(PCSA_OP_JUMP, 11'h7FF);
    chk_pc(13'h0FFF);
    // nine calls overrun the eight entries, then nine returns of all kinds
    for (int i = 0; i < 9; i++)
    begin
      exp_q.push_front(pc + 13'd1);
      op(PCSA_OP_CALL, 11'h100 + 11'(i * 8));
      chk_pc({2'b01, 11'h100 + 11'(i * 8)});
    end
    for (int i = 0; i < 9; i++)
    begin
      op(pops[i % 3], 11'h000);
      chk_pc(exp_q[i % 8]);
    end
    rd_chk(8'h04, 8'h0F);
    wr(8'h04, 8'h1F);
    wr(8'h01, 8'hAA);
    saved = pc;
    op(PCSA_OP_IRQ, 11'h000);
    chk_pc(`PCSA_IRQ_VECTOR);
    op(PCSA_OP_INTERRUPT_EXIT, 11'h000);
    chk_pc(saved);
    // back to back call and return, then vectoring and its exit
    op2(PCSA_OP_CALL, PCSA_OP_RET);
    chk_pc(13'h1FAB);
    op2(PCSA_OP_IRQ, PCSA_OP_INTERRUPT_EXIT);
    chk_pc(13'h1FAB);
    // indirect path
    wr(8'h03, 8'h40);
    wr(8'h02, 8'h00);
    chk_data({7'h00, mem_addr}, 16'h0040);
    wr(8'h02, 8'hFF);
    chk_data({7'h00, mem_addr}, 16'h0140);
    rd_chk(8'h02, 8'h80);
    wr(8'h00, 8'h3C);
    chk_data({7'h00, mem_we, mem_wdata}, 16'h013C);
    rd_chk(8'h00, 8'h3C);
    wr(8'h03, 8'h00);
    rd_chk(8'h00, 8'h00);
    wr(8'h00, 8'h55);
    chk_data({15'h0000, mem_we}, 16'h0000);
    rd_chk(8'h7F, 8'h00);
    chk_data({8'h00, i_pcsa_dmem.mem[256]}, 16'h00FF);
    // reset in mid-run
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_pc(13'h0000);
    chk_data({8'h00, rd_data}, 16'h0000);
    @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk_pc(13'h0000);
    // pop right after reset wraps the pointer onto a cleared entry
    op(PCSA_OP_RET, 11'h000);
    chk_pc(13'h0000);
    finish_test;
  end
endmodule : testbench
`default_nettype wire
